// file: hw/dma_dest_cfg.svh
// register offsets, field positions, codes and reset values of the dma channel slice
`ifndef DMA_DEST_CFG_SVH
`define DMA_DEST_CFG_SVH

// register indexes, byte address is four times the index
`define CH_CTRL_IDX 6'h00
`define CH_STATUS_IDX 6'h01
`define ADDR_CTRL_IDX 6'h02
`define TRIG_SEL_IDX 6'h03
`define COUNT_LO_IDX 6'h04
`define COUNT_HI_IDX 6'h05
`define TARGET_PTR_IDX 6'h0c

// channel control fields
`define CTRL_ENABLE_BIT 7
`define CTRL_SWREQ_BIT 4
`define CTRL_SINGLE_BIT 2
`define CTRL_BURST_LSB 0

// channel status fields
`define STAT_BUSY_BIT 7
`define STAT_PEND_BIT 6
`define STAT_DONE_BIT 4

// address control fields
`define ADDR_RET_LSB 2
`define ADDR_STEP_LSB 0

// destination return codes
`define RET_NONE 2'h0
`define RET_BLOCK 2'h1
`define RET_BURST 2'h2
`define RET_TRANSACTION 2'h3

// destination step codes
`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2

// trigger base codes
`define TRIG_OFF 8'h00
`define TRIG_EVT_BASE 8'h01
`define TRIG_CRYPTO_BASE 8'h04
`define TRIG_CONV_BASE 8'h10
`define TRIG_TMR0_C 8'h40
`define TRIG_TMR1_C 8'h46
`define TRIG_SPI_C 8'h4a
`define TRIG_USART_C 8'h4b
`define TRIG_TMR0_D 8'h60
`define TRIG_SPI_D 8'h6a
`define TRIG_USART_D 8'h6b
`define TRIG_TMR0_E 8'h80
`define TRIG_USART_E 8'h8b
`define TRIG_TMR0_F 8'ha0
`define TRIG_USART_F 8'hab

// trigger counts per module type
`define TRIG_EVT_N 8'h03
`define TRIG_TMR0_N 8'h06
`define TRIG_TMR1_N 8'h04
`define TRIG_USART_N 8'h02

// reset values, and the count loaded when a block starts at zero
`define COUNT_RESET 16'h0001
`define COUNT_ZERO_LOAD 16'hffff
`define TRIG_SEL_RESET 8'h00

`endif

// file: hw/dma_dest_pkg.sv
// types shared by the dma channel slice
package dma_dest_pkg;

   // channel sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_MOVE
   } chan_state_t;

   // complete channel state, registered as one word
   typedef struct packed {
      chan_state_t state;
      logic ack;
      logic [31:0] rdata;
      logic enable;
      logic single;
      logic [1:0] burst_len;
      logic sw_req;
      logic busy;
      logic done;
      logic [1:0] dest_return_sel;
      logic [1:0] dest_step_sel;
      logic [7:0] trigger_select;
      logic [15:0] block_byte_count;
      logic [15:0] count_reload;
      logic [7:0] temp;
      logic [23:0] target_pointer;
      logic [23:0] pointer_init;
      logic [3:0] burst_left;
      logic trig_ack;
   } chan_reg_t;

endpackage

// file: hw/trig_if.sv
// selector and decoded hit between channel and trigger decoder
`timescale 1ns/1ps
interface trig_if;
   logic [7:0] sel; // current selector code
   logic hit; // selected request is active

   modport chan (output sel, input hit);
   modport dec (input sel, output hit);
endinterface

// file: hw/trig_decode.sv
// trigger selector decoder for the dma channel
`timescale 1ns/1ps
`include "dma_dest_cfg.svh"
module trig_decode import dma_dest_pkg::*; #(
   parameter logic [13:0] PRESENT = 14'h3fff
) (
   trig_if.dec trig,
   input wire logic [2:0] evt_req,
   input wire logic crypto_req,
   input wire logic conv_req,
   input wire logic [23:0] tmr0_req,
   input wire logic [3:0] tmr1_req,
   input wire logic [1:0] spi_req,
   input wire logic [7:0] usart_req
);

   // first timer bases, ports c d e f
   localparam logic [7:0] TMR0_BASE [4] = '{`TRIG_TMR0_C, `TRIG_TMR0_D, `TRIG_TMR0_E, `TRIG_TMR0_F};
   // serial bases, ports c d e f
   localparam logic [7:0] USART_BASE [4] = '{`TRIG_USART_C, `TRIG_USART_D, `TRIG_USART_E, `TRIG_USART_F};
   localparam logic [7:0] SPI_BASE [2] = '{`TRIG_SPI_C, `TRIG_SPI_D};
   // presence bit of each module
   localparam int TMR0_PRES [4] = '{3, 7, 10, 12};
   localparam int USART_PRES [4] = '{6, 9, 11, 13};
   localparam int SPI_PRES [2] = '{5, 8};

   // true when code lies in base .. base+n-1
   function automatic logic in_range(input logic [7:0] code, input logic [7:0] base, input logic [7:0] n);
      in_range = (code >= base) && ((code - base) < n);
   endfunction

   // pick the one request named by the selector
   always_comb begin
      logic [7:0] off;
      off = 8'h00;
      trig.hit = 1'b0; // absent modules and unused codes give nothing R12
      if (in_range(trig.sel, `TRIG_EVT_BASE, `TRIG_EVT_N)) begin
         off = trig.sel - `TRIG_EVT_BASE;
         trig.hit = PRESENT[0] & evt_req[off[1:0]]; // R8
      end
      if (trig.sel == `TRIG_CRYPTO_BASE) begin
         trig.hit = PRESENT[1] & crypto_req; // R7
      end
      if (trig.sel == `TRIG_CONV_BASE) begin
         trig.hit = PRESENT[2] & conv_req; // R7
      end
      for (int i = 0; i < 4; i++) begin
         if (in_range(trig.sel, TMR0_BASE[i], `TRIG_TMR0_N)) begin
            off = trig.sel - TMR0_BASE[i];
            trig.hit = PRESENT[TMR0_PRES[i]] & tmr0_req[i*6 + int'(off[2:0])]; // R9
         end
         if (trig.sel == USART_BASE[i] || trig.sel == USART_BASE[i] + 8'h01) begin
            off = trig.sel - USART_BASE[i];
            trig.hit = PRESENT[USART_PRES[i]] & usart_req[i*2 + int'(off[0])]; // R11
         end
      end
      // second timer type has no compare c or d R10
      if (in_range(trig.sel, `TRIG_TMR1_C, `TRIG_TMR1_N)) begin
         off = trig.sel - `TRIG_TMR1_C;
         trig.hit = PRESENT[4] & tmr1_req[off[1:0]]; // R9
      end
      for (int i = 0; i < 2; i++) begin
         if (trig.sel == SPI_BASE[i]) begin
            trig.hit = PRESENT[SPI_PRES[i]] & spi_req[i]; // R7
         end
      end
   end

endmodule

// file: hw/dma_dest_chan.sv
// dma channel slice: destination return and step, trigger select, block byte count
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "dma_dest_cfg.svh"
// Summary of operation
// R1 - return field picks when pointer restores
// R2 - return field frozen while channel busy
// R3 - step field: fixed, increment, decrement; 11 reserved
// R4 - step field frozen while channel busy
// R5 - selector chooses trigger; zero means software only
// R6 - software adds offset to module base
// R7 - decode event, crypto, converter, timer, serial bases
// R8 - event offsets select event channels zero to two
// R9 - timer offsets: wrap, error, compare a-d
// R10 - compare c and d only on first timers
// R11 - serial offsets: receive done, transmit empty
// R12 - absent module codes yield no trigger
// R13 - withdrawn peripheral request is simply lost
// R14 - peripheral drops request when its register accessed
// R15 - sixteen bit count, minus one per byte
// R16 - count restores last written value at zero
// R17 - count zero gives 0xffff byte transfers
// R18 - count resets to one
// R19 - pointer steps after each byte per step field
// R20 - count bytes pass through shared temp byte
// R21 - hardware trigger needs enable and nonzero selector
module dma_dest_chan import dma_dest_pkg::*; #(
   parameter logic [13:0] PRESENT = 14'h3fff
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // trigger requests from peripherals
   input wire logic [2:0] evt_req,
   input wire logic crypto_req,
   input wire logic conv_req,
   input wire logic [23:0] tmr0_req,
   input wire logic [3:0] tmr1_req,
   input wire logic [1:0] spi_req,
   input wire logic [7:0] usart_req,
   output logic trigger_ack,
   // byte mover handshake
   output logic xfer_req,
   output logic [23:0] xfer_addr,
   input wire logic xfer_done,
   output logic chan_busy
);

   chan_reg_t st_r; // registered state
   chan_reg_t st_nxt; // next state
   trig_if trig ();

   // decoder sees the live selector
   assign trig.sel = st_r.trigger_select;

   trig_decode #(
      .PRESENT(PRESENT)
   ) u_decode (
      .trig(trig),
      .evt_req(evt_req),
      .crypto_req(crypto_req),
      .conv_req(conv_req),
      .tmr0_req(tmr0_req),
      .tmr1_req(tmr1_req),
      .spi_req(spi_req),
      .usart_req(usart_req)
   );

   // bytes in one burst from the two bit code
   function automatic logic [3:0] burst_bytes(input logic [1:0] code);
      burst_bytes = 4'h1 << code;
   endfunction

   // next pointer after one byte
   function automatic logic [23:0] step_ptr(input logic [23:0] ptr, input logic [1:0] mode);
      unique case (mode)
         `STEP_INC: step_ptr = ptr + 24'h000001;
         `STEP_DEC: step_ptr = ptr - 24'h000001;
         default: step_ptr = ptr; // fixed, and reserved code held fixed
      endcase
   endfunction

   // combinational next state
   always_comb begin
      logic bus_go;
      logic wr;
      logic rd;
      logic [5:0] idx;
      logic trig_hw;
      logic start;
      logic [15:0] cnt_dec;
      logic [7:0] wbyte;
      bus_go = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      idx = 6'h00;
      trig_hw = 1'b0;
      start = 1'b0;
      cnt_dec = 16'h0000;
      wbyte = 8'h00;
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.trig_ack = 1'b0;

      // bus decode; one cycle wait, ack dropped the cycle after
      bus_go = wb_cyc_i & wb_stb_i & ~st_r.ack;
      wr = bus_go & wb_we_i;
      rd = bus_go & ~wb_we_i;
      idx = wb_adr_i[7:2];
      wbyte = wb_dat_i[7:0];
      if (bus_go) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = 32'h00000000; // unmapped reads return zero
      end

      // register reads
      if (rd) begin
         unique case (idx)
            `CH_CTRL_IDX: begin
               st_nxt.rdata[`CTRL_ENABLE_BIT] = st_r.enable;
               st_nxt.rdata[`CTRL_SWREQ_BIT] = st_r.sw_req;
               st_nxt.rdata[`CTRL_SINGLE_BIT] = st_r.single;
               st_nxt.rdata[`CTRL_BURST_LSB +: 2] = st_r.burst_len;
            end
            `CH_STATUS_IDX: begin
               st_nxt.rdata[`STAT_BUSY_BIT] = st_r.busy;
               st_nxt.rdata[`STAT_PEND_BIT] = (st_r.state == ST_ARMED) & trig.hit;
               st_nxt.rdata[`STAT_DONE_BIT] = st_r.done;
            end
            `ADDR_CTRL_IDX: begin
               st_nxt.rdata[`ADDR_RET_LSB +: 2] = st_r.dest_return_sel;
               st_nxt.rdata[`ADDR_STEP_LSB +: 2] = st_r.dest_step_sel;
            end
            `TRIG_SEL_IDX: st_nxt.rdata[7:0] = st_r.trigger_select;
            `COUNT_LO_IDX: begin
               // low read parks high byte so the pair reads atomically
               st_nxt.rdata[7:0] = st_r.block_byte_count[7:0];
               st_nxt.temp = st_r.block_byte_count[15:8]; // R20
            end
            `COUNT_HI_IDX: st_nxt.rdata[7:0] = st_r.temp; // R20
            `TARGET_PTR_IDX: st_nxt.rdata[23:0] = st_r.target_pointer;
            default: ;
         endcase
      end

      // register writes, byte lane zero carries the 8-bit registers
      if (wr && wb_sel_i[0]) begin
         unique case (idx)
            `CH_CTRL_IDX: begin
               st_nxt.enable = wbyte[`CTRL_ENABLE_BIT];
               // single shot only changes while disabled
               if (!st_r.enable) begin
                  st_nxt.single = wbyte[`CTRL_SINGLE_BIT];
               end
               if (!st_r.busy) begin
                  st_nxt.burst_len = wbyte[`CTRL_BURST_LSB +: 2];
               end
               // software request only counts on an enabled channel
               if (wbyte[`CTRL_SWREQ_BIT] && wbyte[`CTRL_ENABLE_BIT]) begin
                  st_nxt.sw_req = 1'b1;
               end
            end
            `CH_STATUS_IDX: begin
               if (wbyte[`STAT_DONE_BIT]) begin
                  st_nxt.done = 1'b0; // write one clears, engine set below wins
               end
            end
            `ADDR_CTRL_IDX: begin
               if (!st_r.busy) begin
                  st_nxt.dest_return_sel = wbyte[`ADDR_RET_LSB +: 2]; // R2 R1
                  st_nxt.dest_step_sel = wbyte[`ADDR_STEP_LSB +: 2]; // R4 R3
               end
            end
            `TRIG_SEL_IDX: st_nxt.trigger_select = wbyte; // R5
            `COUNT_LO_IDX: st_nxt.temp = wbyte; // R20
            `COUNT_HI_IDX: begin
               // high write commits both bytes at once
               st_nxt.count_reload = {wbyte, st_r.temp}; // R20 R16
               if (!st_r.busy) begin
                  st_nxt.block_byte_count = {wbyte, st_r.temp};
               end
            end
            default: ;
         endcase
      end
      // pointer takes each written byte lane, start value kept for returns
      if (wr && idx == `TARGET_PTR_IDX) begin
         for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
               st_nxt.pointer_init[b*8 +: 8] = wb_dat_i[b*8 +: 8];
               st_nxt.target_pointer[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
         end
      end

      // a hardware request counts only on an enabled channel with a selector
      trig_hw = trig.hit & (st_r.trigger_select != `TRIG_OFF) & st_r.enable; // R21 R5
      start = trig_hw | st_r.sw_req;
      cnt_dec = st_r.block_byte_count - 16'h0001;

      // channel sequencer
      unique case (st_r.state)
         ST_IDLE: begin
            if (st_r.enable) begin
               st_nxt.state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!st_r.enable) begin
               st_nxt.state = ST_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.sw_req = 1'b0;
            end else if (start) begin
               // a request withdrawn before this edge was never seen R13
               st_nxt.state = ST_MOVE;
               st_nxt.busy = 1'b1;
               st_nxt.sw_req = 1'b0;
               st_nxt.trig_ack = trig_hw; // lets the source withdraw R14
               st_nxt.burst_left = burst_bytes(st_r.burst_len); // bytes left in the burst that starts here, from burst_len
               if (!st_r.busy && st_r.block_byte_count == 16'h0000) begin
                  st_nxt.block_byte_count = `COUNT_ZERO_LOAD; // R17
               end
            end
         end
         ST_MOVE: begin
            if (!st_r.enable) begin
               // software disable aborts mid block
               st_nxt.state = ST_IDLE;
               st_nxt.busy = 1'b0;
            end else if (xfer_done) begin
               st_nxt.target_pointer = step_ptr(st_r.target_pointer, st_r.dest_step_sel); // R19
               st_nxt.block_byte_count = cnt_dec; // R15
               st_nxt.burst_left = st_r.burst_left - 4'h1;
               if (cnt_dec == 16'h0000) begin
                  // block end, which here is also transaction end
                  st_nxt.block_byte_count = st_r.count_reload; // R16
                  st_nxt.state = ST_IDLE;
                  st_nxt.busy = 1'b0;
                  st_nxt.enable = 1'b0;
                  st_nxt.done = 1'b1;
                  if (st_r.dest_return_sel != `RET_NONE) begin
                     st_nxt.target_pointer = st_r.pointer_init; // R1
                  end
               end else if (st_r.burst_left == 4'h1) begin
                  if (st_r.dest_return_sel == `RET_BURST) begin
                     st_nxt.target_pointer = st_r.pointer_init; // R1
                  end
                  // single shot waits for the next trigger per burst
                  if (st_r.single) begin
                     st_nxt.state = ST_ARMED;
                  end else begin
                     st_nxt.burst_left = burst_bytes(st_r.burst_len);
                  end
               end
            end
         end
         // unused state code falls back to idle
         default: st_nxt.state = ST_IDLE;
      endcase
   end

   // state register, frozen while clock enable is low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.state <= ST_IDLE;
         st_r.trigger_select <= `TRIG_SEL_RESET;
         st_r.block_byte_count <= `COUNT_RESET; // R18
         st_r.count_reload <= `COUNT_RESET; // R18
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign wb_dat_o = st_r.rdata;
   assign wb_ack_o = st_r.ack;
   assign trigger_ack = st_r.trig_ack;
   assign xfer_req = (st_r.state == ST_MOVE) & st_r.enable;
   assign xfer_addr = st_r.target_pointer;
   assign chan_busy = st_r.busy;

endmodule

// file: tb/dma_dest_chan_assertions.sv
// port-level checks of the dma channel slice
`timescale 1ns/1ps
module dma_dest_chan_assertions (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [2:0] evt_req,
   input wire logic crypto_req,
   input wire logic conv_req,
   input wire logic [23:0] tmr0_req,
   input wire logic [3:0] tmr1_req,
   input wire logic [1:0] spi_req,
   input wire logic [7:0] usart_req,
   input wire logic trigger_ack,
   input wire logic xfer_req,
   input wire logic [23:0] xfer_addr,
   input wire logic xfer_done,
   input wire logic chan_busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // some peripheral request is up
   wire any_req = |{evt_req, crypto_req, conv_req, tmr0_req, tmr1_req, spi_req, usart_req};
   // bus request not yet answered
   sequence bus_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // one-cycle answer
   sequence ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   bus_answer_a: assert property (bus_take |=> ack_once) else $error("bus answer late or long");
   trig_pulse_a: assert property (trigger_ack |=> !trigger_ack) else $error("trigger ack too long");
   trig_start_a: assert property (trigger_ack |-> xfer_req && chan_busy) else $error("trigger did not start");
   trig_idle_a: assert property (trigger_ack |-> !$past(xfer_req)) else $error("trigger taken while moving");
   trig_cause_a: assert property (trigger_ack |-> $past(any_req)) else $error("trigger without request");
   req_busy_a: assert property (xfer_req |-> chan_busy) else $error("byte request while idle");
   // pointer moves only on a byte or a bus write
   ptr_hold_a: assert property (!(xfer_req && xfer_done) && !(wb_cyc_i && wb_stb_i && wb_we_i)
      |=> $stable(xfer_addr)) else $error("pointer moved alone");
   busy_end_a: assert property ($fell(chan_busy) |-> !xfer_req) else $error("request after block end");
endmodule
bind dma_dest_chan dma_dest_chan_assertions chk (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .evt_req, .crypto_req, .conv_req, .tmr0_req, .tmr1_req, .spi_req, .usart_req, .trigger_ack,
   .xfer_req, .xfer_addr, .xfer_done, .chan_busy);

// file: tb/byte_mover_model.sv
// byte mover stand-in: answers byte requests, logs addresses
`timescale 1ns/1ps
module byte_mover_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic xfer_req,
   input wire logic [23:0] xfer_addr,
   input wire logic [3:0] gap,
   output logic xfer_done
);
   logic [3:0] wait_r; // idle cycles left before next byte
   logic [23:0] seen[$]; // address of every finished byte
   // one byte per done cycle; gap sets slow or prompt answers
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         xfer_done <= 1'b0;
         wait_r <= 4'h0;
      end else if (xfer_req) begin
         if (xfer_done) seen.push_back(xfer_addr);
         xfer_done <= (wait_r == 4'h0);
         wait_r <= (wait_r == 4'h0) ? gap : wait_r - 4'h1;
      end else begin
         // released: never hold done outside a request
         xfer_done <= 1'b0;
      end
   end
endmodule

// file: tb/dma_dest_chan_bench.sv
// self-checking bench of the dma channel slice
`timescale 1ns/1ps
`include "dma_dest_cfg.svh"
module dma_dest_chan_bench;
   logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, trigger_ack, xfer_req, xfer_done, chan_busy;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [42:0] req_v; // all peripheral requests, packed
   logic [23:0] xfer_addr;
   logic [3:0] gap; // mover answer spacing
   int checks, miscompares;
   // usart f missing from this build
   dma_dest_chan #(.PRESENT(14'h1fff)) dut (.core_clk, .reset_n, .clk_en(1'b1), .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .evt_req(req_v[2:0]),
      .crypto_req(req_v[3]), .conv_req(req_v[4]), .tmr0_req(req_v[28:5]), .tmr1_req(req_v[32:29]),
      .spi_req(req_v[34:33]), .usart_req(req_v[42:35]), .trigger_ack, .xfer_req, .xfer_addr, .xfer_done,
      .chan_busy);
   byte_mover_model mv (.core_clk, .reset_n, .xfer_req, .xfer_addr, .gap, .xfer_done);
   // clock, 40 ns period
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // classic single cycle, held until ack
   task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0, q);
      chk(q, exp);
   endtask
   // bounded wait on the busy port
   task automatic waitb(input logic v);
      int n;
      n = 0;
      while (chan_busy !== v && n < 70000) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, chan_busy}, {31'h0, v});
   endtask
   // hang guard, well beyond the longest block
   initial begin
      repeat (90000) @(posedge core_clk);
      miscompares++;
      conclude();
   end
   initial begin
      logic [7:0] ts[11] = '{8'h03, 8'h04, 8'h10, 8'h45, 8'h49, 8'h6a, 8'h8c, 8'h80, 8'hab, 8'h00, 8'h04};
      int tbit[11] = '{2, 3, 4, 10, 32, 34, 40, 17, 41, 3, 3};
      logic [23:0] p, ea;
      int n, st, rt, d, got;
      reset_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      req_v = '0;
      gap = 4'h0;
      checks = 0;
      miscompares = 0;
      void'($urandom(86095));
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      // reset values, unmapped place, paired count access
      rdchk(`TRIG_SEL_IDX, 32'h0);
      rdchk(`COUNT_LO_IDX, 32'h1);
      rdchk(`COUNT_HI_IDX, 32'h0);
      rdchk(6'h3f, 32'h0);
      wr(`COUNT_LO_IDX, 32'h34);
      wr(`COUNT_HI_IDX, 32'h12);
      rdchk(`COUNT_LO_IDX, 32'h34);
      rdchk(`COUNT_HI_IDX, 32'h12);
      // software blocks over every step and return code
      for (int c = 0; c < 8; c++) begin
         st = c % 3;
         rt = c % 4;
         d = (st == 1) ? 1 : (st == 2) ? -1 : 0;
         gap <= (c % 2) ? 4'h3 : 4'h0;
         n = (c % 2) ? 8 : 1 + $urandom % 8;
         p = 24'($urandom);
         wr(`ADDR_CTRL_IDX, 32'(rt * 4 + st));
         wr(`COUNT_LO_IDX, 32'(n));
         wr(`COUNT_HI_IDX, 32'h0);
         wr(`TARGET_PTR_IDX, {8'h0, p});
         mv.seen.delete();
         wr(`CH_CTRL_IDX, 32'h90);
         // block starts two cycles after the enable lands
         waitb(1'b1);
         if (c % 2) begin
            // slow mover keeps the channel busy across these
            wr(`ADDR_CTRL_IDX, 32'h0f);
            rdchk(`ADDR_CTRL_IDX, 32'(rt * 4 + st));
         end
         waitb(1'b0);
         chk(32'(mv.seen.size()), 32'(n));
         for (int k = 0; k < mv.seen.size(); k++) begin
            ea = (rt == 2) ? p : p + 24'(k * d);
            chk({8'h0, mv.seen[k]}, {8'h0, ea});
         end
         ea = (rt == 0) ? p + 24'(n * d) : p;
         rdchk(`TARGET_PTR_IDX, {8'h0, ea});
         rdchk(`COUNT_LO_IDX, 32'(n));
      end
      // hardware triggers: present, absent, zero selector, disabled
      gap <= 4'h0;
      for (int i = 0; i < 11; i++) begin
         wr(`TRIG_SEL_IDX, {24'h0, ts[i]});
         wr(`COUNT_LO_IDX, 32'h1);
         wr(`CH_CTRL_IDX, (i == 10) ? 32'h0 : 32'h80);
         repeat (2) @(posedge core_clk);
         req_v <= 43'h1 << tbit[i];
         got = 0;
         repeat (8) begin
            @(posedge core_clk);
            if (trigger_ack === 1'b1) begin
               got = 1;
               req_v <= '0;
            end
         end
         req_v <= '0;
         chk(32'(got), (i < 8) ? 32'h1 : 32'h0);
         waitb(1'b0);
         wr(`CH_CTRL_IDX, 32'h0);
      end
      // zero count runs the long block
      wr(`ADDR_CTRL_IDX, 32'h1);
      wr(`COUNT_LO_IDX, 32'h0);
      wr(`COUNT_HI_IDX, 32'h0);
      mv.seen.delete();
      wr(`CH_CTRL_IDX, 32'h90);
      waitb(1'b1);
      waitb(1'b0);
      chk(32'(mv.seen.size()), 32'hffff);
      rdchk(`COUNT_LO_IDX, 32'h0);
      conclude();
   end
endmodule
